// ==== sbd_pkg.sv ====
// Purpose: Shared constants and types for the system bus deadlock controller
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes:   Pin bit positions index the synchroniser vector
package sbd_pkg;

  // Synchronised pin vector layout
  localparam int PIN_W        = 4;
  localparam int PIN_HBR      = 0;
  localparam int PIN_SUSPEND_BUS_TRISTATE     = 1;
  localparam int PIN_SBG      = 2;
  localparam int PIN_ACK      = 3;

  // Reset values of the pins, status outputs and synchroniser
  localparam logic RST_PIN_N  = 1'b1;
  localparam logic RST_STAT   = 1'b0;
  localparam logic RST_SYNC   = 1'b0;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_ACCESS,
    ST_GRANTED,
    ST_RESTART
  } sbd_state_t;

endpackage : sbd_pkg

// ==== sbd_pin_if.sv ====
// Purpose: Carries raw pin levels to the synchroniser and synced levels back
// Assumes: Both ends on I_CLOCK
// Notes:   Raw side is already converted to active high
`timescale 1ns/1ps
interface sbd_pin_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface : sbd_pin_if

// ==== sbd_sync.sv ====
// Purpose: Two-flop synchroniser for the asynchronous handshake pins
// Assumes: Synchronous active-low reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sbd_sync
  import sbd_pkg::*;
#(
  parameter int W = PIN_W
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Pin levels
  sbd_pin_if.syn    pins
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;

  always_comb
  begin
    next_meta   = pins.raw;
    next_stable = meta;
    if (!i_rst_n)
    begin
      next_meta   = {W{RST_SYNC}};
      next_stable = {W{RST_SYNC}};
    end
  end

  always_ff @(posedge i_clk)
  begin
    meta   <= next_meta;
    stable <= next_stable;
  end

  assign pins.sync = stable;

endmodule : sbd_sync

// ==== sbd_ctrl.sv ====
// Purpose: External port arbitration between core/DMA accesses and a host, with suspend
// Assumes: Pins are asynchronous and synchronised; core inputs share I_CLOCK
// Notes:   Pin levels are seen two cycles late through the synchroniser
//
// Overview of operation
// - A core access to bank 3 drives its select, which also raises system request.
// - Conditional jump form aborts the access and branches when system grant is false.
// - Without suspend, host grant is asserted only after the current external access has finished.
// - A stuck system bus access keeps host grant inactive; both sides stall.
// - Suspend plus host request enters slave mode, suspends access, grants host.
// - Suspension only for core accesses with no page miss and bus lock off.
// - Suspend seen a cycle after host request gives host grant the next cycle.
// - After request release, host grant drops only once the read buffer is empty.
// - One cycle after host grant drops, the suspended access restarts.
// - A started DMA word must finish; host grant waits for its acknowledge.
`timescale 1ns/1ps
module sbd_ctrl
  import sbd_pkg::*;
(
  // Clock and reset
  input  wire logic I_CLOCK,
  input  wire logic I_RST_N,
  // Pins from the bus (asynchronous)
  input  wire logic I_HOST_BUS_REQUEST_N,
  input  wire logic I_SUSPEND_BUS_TRISTATE_N,
  input  wire logic I_SYSTEM_BUS_GRANT_N,
  input  wire logic I_ACK,
  // Core and DMA side (same clock)
  input  wire logic i_core_start,
  input  wire logic i_dma_start,
  input  wire logic i_bank3,
  input  wire logic i_cond_jump,
  input  wire logic i_page_miss,
  input  wire logic i_bus_lock,
  input  wire logic i_rd_buf_empty,
  // Pins to the bus
  output logic      O_MEMORY_SELECT_3_N,
  output logic      O_SYSTEM_BUS_REQUEST_N,
  output logic      O_HOST_BUS_GRANT_N,
  // Status to core and DMA
  output logic      O_READY,
  output logic      O_ACCESS_ACTIVE,
  output logic      O_SLAVE_MODE,
  output logic      O_DONE,
  output logic      O_ABORT,
  output logic      O_RESTART
);
  import sbd_pkg::*;

  sbd_pin_if #(.W(PIN_W)) pins ();

  sbd_sync #(.W(PIN_W)) sbd_sync_i
  (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .pins    (pins.syn)
  );

  assign pins.raw = {I_ACK, ~I_SYSTEM_BUS_GRANT_N, ~I_SUSPEND_BUS_TRISTATE_N, ~I_HOST_BUS_REQUEST_N};

  logic host_bus_request;
  logic suspend_bus_tristate;
  logic system_bus_grant;
  logic ack;
  assign host_bus_request  = pins.sync[PIN_HBR];
  assign suspend_bus_tristate = pins.sync[PIN_SUSPEND_BUS_TRISTATE];
  assign system_bus_grant  = pins.sync[PIN_SBG];
  assign ack  = pins.sync[PIN_ACK];

  sbd_state_t state;
  sbd_state_t next_state;
  logic       bank3_q;
  logic       dma_q;
  logic       susp_q;
  logic       next_bank3;
  logic       next_dma;
  logic       next_susp;
  logic       next_done;
  logic       next_abort;
  logic       next_restart;
  logic       suspend_ok;
  logic       start;
  logic       abort_now;

  // Only a plain core access may be frozen mid-flight
  assign suspend_ok = !dma_q && !i_page_miss && !i_bus_lock;
  assign start      = i_core_start || i_dma_start;
  // Conditional form with grant false never touches the bus
  assign abort_now  = i_core_start && i_bank3 && i_cond_jump && !system_bus_grant;

  always_comb
  begin
    next_state   = state;
    next_bank3   = bank3_q;
    next_dma     = dma_q;
    next_susp    = susp_q;
    next_done    = 1'b0;
    next_abort   = 1'b0;
    next_restart = 1'b0;
    case (state)
      ST_IDLE:
      begin
        // Host wins an idle bus; no access in flight
        if (host_bus_request)
        begin
          next_state = ST_GRANTED;
          next_susp  = 1'b0;
        end
        else if (abort_now)
          next_abort = 1'b1;
        else if (start)
        begin
          next_state = ST_ACCESS;
          next_bank3 = i_bank3;
          next_dma   = i_dma_start && !i_core_start;
        end
      end
      ST_ACCESS:
      begin
        if (ack)
        begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
        else if (host_bus_request && suspend_bus_tristate && suspend_ok)
        begin
          next_state = ST_GRANTED;
          next_susp  = 1'b1;
        end
        // Otherwise keep waiting: grant withheld, deadlock persists
      end
      ST_GRANTED:
      begin
        // Pending reads must drain before the host loses the bus
        if (!host_bus_request && i_rd_buf_empty)
          next_state = susp_q ? ST_RESTART : ST_IDLE;
      end
      ST_RESTART:
      begin
        next_state   = ST_ACCESS;
        next_restart = 1'b1;
        next_susp    = 1'b0;
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (!I_RST_N)
    begin
      next_state = ST_IDLE;
      next_bank3 = RST_STAT;
      next_dma   = RST_STAT;
      next_susp  = RST_STAT;
      next_done  = RST_STAT;
      next_abort = RST_STAT;
      next_restart = RST_STAT;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    state   <= next_state;
    bank3_q <= next_bank3;
    dma_q   <= next_dma;
    susp_q  <= next_susp;
  end

  // Outputs are decoded from next values so each comes straight from a flop
  logic next_ms3_n;
  logic next_hbg_n;

  always_comb
  begin
    next_ms3_n = !(next_state == ST_ACCESS && next_bank3);
    next_hbg_n = !(next_state == ST_GRANTED);
    if (!I_RST_N)
    begin
      next_ms3_n = RST_PIN_N;
      next_hbg_n = RST_PIN_N;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    O_MEMORY_SELECT_3_N    <= next_ms3_n;
    // Request mirrors the bank 3 select
    O_SYSTEM_BUS_REQUEST_N <= next_ms3_n;
    O_HOST_BUS_GRANT_N     <= next_hbg_n;
    O_READY                <= (next_state == ST_IDLE) && I_RST_N;
    O_ACCESS_ACTIVE        <= (next_state == ST_ACCESS);
    O_SLAVE_MODE           <= (next_state == ST_GRANTED);
    O_DONE                 <= next_done;
    O_ABORT                <= next_abort;
    O_RESTART              <= next_restart;
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  chk_select_raises_req: assert property (
    (state == ST_IDLE && !host_bus_request && !abort_now && i_core_start && i_bank3)
      |=> (!O_MEMORY_SELECT_3_N && !O_SYSTEM_BUS_REQUEST_N))
    else $error("bank 3 start did not raise select and request");

  chk_cond_abort: assert property (
    (state == ST_IDLE && !host_bus_request && i_core_start && i_bank3 && i_cond_jump && !system_bus_grant)
      |=> (O_ABORT && O_MEMORY_SELECT_3_N && O_READY))
    else $error("conditional access not aborted");

  chk_grant_after_done: assert property (
    (state == ST_ACCESS && ack) |=> (O_HOST_BUS_GRANT_N && O_DONE ##1 (state == ST_GRANTED || !$past(host_bus_request))))
    else $error("host grant not given after access completion");

  chk_stall_no_grant: assert property (
    (state == ST_ACCESS && !ack && !suspend_bus_tristate) |=> (O_HOST_BUS_GRANT_N && O_ACCESS_ACTIVE))
    else $error("host granted during unfinished access");

  chk_suspend_slave: assert property (
    (state == ST_ACCESS && !ack && host_bus_request && suspend_bus_tristate && suspend_ok)
      |=> (O_SLAVE_MODE && O_MEMORY_SELECT_3_N && !O_HOST_BUS_GRANT_N))
    else $error("suspend did not enter slave mode");

  chk_suspend_cond: assert property (
    (state == ST_ACCESS && !ack && (i_page_miss || i_bus_lock)) |=> (state == ST_ACCESS))
    else $error("access suspended despite page miss or lock");

  chk_grant_next_cycle: assert property (
    (host_bus_request ##1 (state == ST_ACCESS && !ack && host_bus_request && suspend_bus_tristate && !dma_q && !i_page_miss && !i_bus_lock))
      |=> $fell(O_HOST_BUS_GRANT_N))
    else $error("host grant missing one cycle after suspend");

  chk_drain_release: assert property (
    (state == ST_GRANTED && !i_rd_buf_empty) |=> !O_HOST_BUS_GRANT_N)
    else $error("host grant dropped with read buffer not empty");

  chk_restart_after: assert property (
    (state == ST_GRANTED && susp_q && !host_bus_request && i_rd_buf_empty)
      |=> (O_HOST_BUS_GRANT_N && !O_ACCESS_ACTIVE) ##1 (O_ACCESS_ACTIVE && O_RESTART))
    else $error("suspended access not restarted one cycle after grant drop");

  chk_dma_no_suspend: assert property (
    (state == ST_ACCESS && dma_q && !ack) |=> (O_HOST_BUS_GRANT_N [*1] and state == ST_ACCESS))
    else $error("dma word interrupted before acknowledge");

  cov_deadlock_break: cover property (state == ST_ACCESS ##1 state == ST_GRANTED ##[1:20] state == ST_RESTART);
  cov_plain_grant:    cover property (state == ST_IDLE ##1 state == ST_GRANTED ##[1:20] state == ST_IDLE);
  cov_abort:          cover property (O_ABORT);
  cov_done:           cover property (O_DONE);

endmodule : sbd_ctrl

// ==== sbd_host_model.sv ====
// Purpose: Host and system side model for request, suspend, grant and acknowledge
// Assumes: Pins change just after I_CLOCK rises
// Notes:   Suspend always drops a cycle before request
`timescale 1ns/1ps
module sbd_host_model
(
  // Clock
  input  wire logic i_clk,
  // Commands from the bench
  input  wire logic i_want_bus,
  input  wire logic i_want_suspend,
  input  wire logic i_grant_sys,
  input  wire logic i_ack_en,
  // Device status watched
  input  wire logic i_access_active,
  // Driven pins
  output logic      o_hbr_n,
  output logic      o_suspend_bus_tristate_n,
  output logic      o_sbg_n,
  output logic      o_ack
);
  initial
  begin
    o_hbr_n  = 1'b1;
    o_suspend_bus_tristate_n = 1'b1;
    o_sbg_n  = 1'b1;
    o_ack    = 1'b0;
  end

  always @(posedge i_clk)
  begin
    o_suspend_bus_tristate_n <= !(i_want_suspend && i_want_bus);
    // Request held while suspend is still low
    o_hbr_n  <= !(i_want_bus || !o_suspend_bus_tristate_n);
    // Single requester: grant held by the bench until released
    o_sbg_n  <= !i_grant_sys;
    o_ack    <= i_ack_en && !o_sbg_n && i_access_active;
    // Strobes, group decode, settle delay, wait states and the direct host
    // request watch lie past these pins and are not modelled
  end
endmodule : sbd_host_model

// ==== sbd_ctrl_test.sv ====
// Purpose: Self-checking bench for the deadlock controller
// Assumes: 10 MHz clock, inputs change by NBA on the rising edge
// Notes:   Waits are bounded; pins pass a two-flop synchroniser
`timescale 1ns/1ps
module sbd_ctrl_test;
  logic clk = 1'b0, rst_n = 1'b0, core_start = 1'b0, dma_start = 1'b0;
  logic bank3 = 1'b0, cond_jump = 1'b0, page_miss = 1'b0, bus_lock = 1'b0;
  logic rd_buf_empty = 1'b1, want_bus = 1'b0, want_suspend = 1'b0;
  logic grant_sys = 1'b1, ack_en = 1'b0;
  logic hbr_n, suspend_bus_tristate_n, sbg_n, ack, sel_n, sbr_n, hbg_n;
  logic ready, active, slave, done, abort, restart;
  int   errors = 0, total_checks = 0, k;

  always #50 clk = ~clk;

  sbd_host_model sbd_host_model_i (.i_clk(clk), .i_want_bus(want_bus), .i_want_suspend(want_suspend),
    .i_grant_sys(grant_sys), .i_ack_en(ack_en), .i_access_active(active),
    .o_hbr_n(hbr_n), .o_suspend_bus_tristate_n(suspend_bus_tristate_n), .o_sbg_n(sbg_n), .o_ack(ack));

  sbd_ctrl sbd_ctrl_i (.I_CLOCK(clk), .I_RST_N(rst_n), .I_HOST_BUS_REQUEST_N(hbr_n),
    .I_SUSPEND_BUS_TRISTATE_N(suspend_bus_tristate_n), .I_SYSTEM_BUS_GRANT_N(sbg_n), .I_ACK(ack),
    .i_core_start(core_start), .i_dma_start(dma_start), .i_bank3(bank3), .i_cond_jump(cond_jump),
    .i_page_miss(page_miss), .i_bus_lock(bus_lock), .i_rd_buf_empty(rd_buf_empty),
    .O_MEMORY_SELECT_3_N(sel_n), .O_SYSTEM_BUS_REQUEST_N(sbr_n), .O_HOST_BUS_GRANT_N(hbg_n),
    .O_READY(ready), .O_ACCESS_ACTIVE(active), .O_SLAVE_MODE(slave), .O_DONE(done),
    .O_ABORT(abort), .O_RESTART(restart));

  task summarize;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task chk(input logic seen, input logic exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // Sample a little after the edge so its updates have landed
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task wait_hbg(input logic lvl);
    for (k = 0; k < 12 && hbg_n !== lvl; k++) tick(1);
  endtask : wait_hbg

  task wait_done;
    for (k = 0; k < 12 && done !== 1'b1; k++) tick(1);
  endtask : wait_done

  task start(input logic dma, input logic b3, input logic cj);
    @(posedge clk);
    core_start <= !dma;
    dma_start  <= dma;
    bank3      <= b3;
    cond_jump  <= cj;
    @(posedge clk);
    core_start <= 1'b0;
    dma_start  <= 1'b0;
    #1;
  endtask : start

  task t_reset;
    chk(ready, 1'b0, "ready in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk(ready, 1'b1, "ready after reset");
    chk(hbg_n, 1'b1, "grant after reset");
    chk(sel_n, 1'b1, "select after reset");
  endtask : t_reset

  task t_access;
    ack_en <= 1'b1;
    start(1'b0, 1'b1, 1'b0);
    chk(sel_n, 1'b0, "select low");
    chk(sbr_n, 1'b0, "request with select");
    chk(active, 1'b1, "access active");
    chk(ready, 1'b0, "busy during access");
    wait_done();
    chk(done, 1'b1, "access done");
    chk(sel_n, 1'b1, "select released");
    chk(sbr_n, 1'b1, "request released");
    chk(active, 1'b0, "access ended");
    tick(6);
    start(1'b0, 1'b0, 1'b0);
    chk(sel_n, 1'b1, "no select off bank 3");
    chk(sbr_n, 1'b1, "no request off bank 3");
    chk(active, 1'b1, "local access active");
    wait_done();
    chk(done, 1'b1, "local access done");
    tick(6);
  endtask : t_access

  task t_abort;
    grant_sys <= 1'b0;
    tick(5);
    start(1'b0, 1'b1, 1'b1);
    chk(abort, 1'b1, "abort pulse");
    chk(sel_n, 1'b1, "no select on abort");
    chk(ready, 1'b1, "ready after abort");
    tick(1);
    chk(abort, 1'b0, "abort one cycle");
    grant_sys <= 1'b1;
    tick(5);
  endtask : t_abort

  task t_host;
    rd_buf_empty <= 1'b0;
    want_bus     <= 1'b1;
    wait_hbg(1'b0);
    chk(hbg_n, 1'b0, "host grant idle");
    chk(slave, 1'b1, "slave mode");
    want_bus <= 1'b0;
    tick(6);
    chk(hbg_n, 1'b0, "grant held, buffer busy");
    rd_buf_empty <= 1'b1;
    wait_hbg(1'b1);
    chk(hbg_n, 1'b1, "grant dropped");
    tick(4);
  endtask : t_host

  task t_suspend;
    ack_en <= 1'b0;
    start(1'b0, 1'b1, 1'b0);
    want_bus <= 1'b1;
    tick(6);
    chk(hbg_n, 1'b1, "stuck access blocks grant");
    want_suspend <= 1'b1;
    wait_hbg(1'b0);
    chk(hbg_n, 1'b0, "grant on suspend");
    chk(sel_n, 1'b1, "access suspended");
    want_suspend <= 1'b0;
    want_bus     <= 1'b0;
    wait_hbg(1'b1);
    tick(1);
    chk(restart, 1'b1, "restart after grant drop");
    chk(sel_n, 1'b0, "select again");
    ack_en <= 1'b1;
    wait_done();
    chk(done, 1'b1, "restarted access done");
    tick(6);
  endtask : t_suspend

  task t_refuse(input logic dma, input logic miss, input logic lock);
    ack_en    <= 1'b0;
    page_miss <= miss;
    bus_lock  <= lock;
    start(dma, 1'b1, 1'b0);
    want_bus     <= 1'b1;
    want_suspend <= 1'b1;
    tick(10);
    chk(hbg_n, 1'b1, "no suspend allowed");
    ack_en <= 1'b1;
    wait_hbg(1'b0);
    chk(hbg_n, 1'b0, "grant after access end");
    want_suspend <= 1'b0;
    want_bus     <= 1'b0;
    page_miss    <= 1'b0;
    bus_lock     <= 1'b0;
    wait_hbg(1'b1);
    tick(6);
  endtask : t_refuse

  initial
  begin
    #(3000 * 100);
    errors++;
    summarize();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    t_reset();
    t_access();
    t_abort();
    t_host();
    t_suspend();
    t_refuse(1'b1, 1'b0, 1'b0);
    t_refuse(1'b0, 1'b1, 1'b0);
    t_refuse(1'b0, 1'b0, 1'b1);
    summarize();
  end
endmodule : sbd_ctrl_test
